/* File: lrw_pkg.sv */
package lrw_pkg;

  // Register port
  localparam int          REG_AW        = 8;
  localparam int          REG_DW        = 16;
  localparam logic [7:0]  ADDR_PATTERN  = 8'h00;
  localparam logic [7:0]  ADDR_CTRL_A   = 8'h04;
  localparam logic [7:0]  ADDR_CTRL_B   = 8'h08;
  localparam logic [7:0]  ADDR_COMMAND  = 8'h0c;
  localparam logic [7:0]  ADDR_STATUS   = 8'h10;

  // Field positions
  localparam int          CTRLA_PRE_LSB = 0;
  localparam int          CTRLA_PRE_W   = 4;
  localparam int          CTRLA_AUTO    = 4;
  localparam int          CTRLB_THR_LSB = 0;
  localparam int          CTRLB_THR_W   = 5;
  localparam int          CMD_TX_START  = 0;
  localparam int          CMD_UFL_CLEAR = 1;
  localparam int          ST_UNDERFLOW  = 0;
  localparam int          ST_TX_ACTIVE  = 1;
  localparam int          ST_CRC_OK     = 2;
  localparam int          ST_RX_FRAME   = 3;

  // Reset values
  localparam logic [15:0] PATTERN_RST   = 16'ha70f;
  localparam logic [3:0]  PRE_RST       = 4'h6;
  localparam logic        AUTO_RST      = 1'b1;
  localparam logic [4:0]  THR_RST       = 5'h00;
  localparam logic [15:0] CRC_INIT      = 16'h0000;

  // Framing constants
  localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
  localparam logic [3:0]  SYM_IGNORE    = 4'hf;
  localparam logic [3:0]  SYM_ZERO      = 4'h0;
  localparam logic [1:0]  DELIM_LAST    = 2'h3;
  localparam logic [6:0]  FCS_BYTES     = 7'h02;
  localparam logic [3:0]  CORR_SYMS     = 4'h8;
  localparam int          CORR_SHIFT    = 3;
  localparam int          RSSI_SHIFT    = 3;

  typedef enum logic [5:0] {
    TX_IDLE  = 6'b000001,
    TX_PRE   = 6'b000010,
    TX_DELIM = 6'b000100,
    TX_LEN   = 6'b001000,
    TX_BODY  = 6'b010000,
    TX_FCS   = 6'b100000
  } lrw_tx_st_t;

  typedef enum logic [2:0] {
    RX_HUNT  = 3'b001,
    RX_LEN   = 3'b010,
    RX_BODY  = 3'b100
  } lrw_rx_st_t;

  // One byte of CRC-16, bits taken least significant first
  function automatic logic [15:0] lrw_crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      fb = r[0] ^ d[i];
      r  = r >> 1;
      if (fb)
        r = r ^ CRC_POLY_REFL;
    end
    return r;
  endfunction

  // Window match; low-order symbols of 0xf are skipped until the first other symbol
  function automatic logic lrw_delim_match(input logic [15:0] win, input logic [15:0] pat);
    logic skip;
    logic ok;
    skip = 1'b1;
    ok   = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      if (pat[4*i +: 4] != SYM_IGNORE)
        skip = 1'b0;
      if (!skip && (win[4*i +: 4] != pat[4*i +: 4]))
        ok = 1'b0;
    end
    return ok;
  endfunction

endpackage

/* File: lrw_crc16.sv */
`timescale 1ns/1ps
module lrw_crc16
  import lrw_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // Byte input
  input  wire logic        crc_clr,
  input  wire logic        crc_en,
  input  wire logic [7:0]  crc_data,
  // Running remainder
  output logic      [15:0] crc_q
);

  typedef struct packed {
    logic [15:0] crc;
  } lrw_crc_state_t;

  lrw_crc_state_t s_ff;
  lrw_crc_state_t nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    if (crc_clr)
      nxt_s.crc = CRC_INIT;
    else if (crc_en)
      nxt_s.crc = lrw_crc_byte(s_ff.crc, crc_data);
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      s_ff <= '{crc: CRC_INIT};
    else
      s_ff <= nxt_s;
  end

  assign crc_q = s_ff.crc;

endmodule // lrw_crc16

/* File: lrw_frame_formatter.sv */
// Summary of operation
// - Default header sends eight zero symbols then delimiter byte 0xA7.
// - Preamble and delimiter always go out before the length byte.
// - Preamble length setting changes only transmitted zero symbols, not reception.
// - Pattern is 16 bits; preamble counter defaults to six symbols.
// - Receive search skips low-order 0xF symbols, matches all others exactly.
// - Default pattern 0xA70F needs one extra zero symbol before the delimiter.
// - Bytes after the delimiter go to the receive buffer; delimiter never.
// - Delimiter search runs on every received symbol whenever no frame is open.
// - Length is seven bits, maximum 127; top bit reserved and ignored.
// - Length counts every MPDU byte including check bytes, not itself.
// - Length bounds both directions; transmit stops on buffer underflow.
// - CRC-16 x^16+x^12+x^5+1 over MPDU bytes only.
// - Auto-check bit enables hardware generation of the check bytes; the receive CRC check sets status whether or not it is set.
// - Transmit appends check bytes from a 16-bit register, not the buffer.
// - Receive drops first check byte and stores signal strength instead.
// - Final stored byte bits 6:0 hold average correlation of first eight symbols.
// - Final stored byte bit 7 is one when CRC passed, else zero.
// - Signal strength stored is averaged over the received frame.
`timescale 1ns/1ps
module lrw_frame_formatter
  import lrw_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              srst,
  // Register port
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [REG_DW-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [REG_DW-1:0] reg_rdata,
  // Transmit buffer
  input  wire logic              txb_avail,
  input  wire logic [7:0]        txb_data,
  output logic                   txb_pop,
  // Transmit symbols to modem
  output logic      [3:0]        tx_sym,
  output logic                   tx_sym_valid,
  input  wire logic              tx_sym_ready,
  // Receive symbols from modem
  input  wire logic [3:0]        rx_sym,
  input  wire logic              rx_sym_valid,
  input  wire logic [6:0]        rx_corr,
  input  wire logic [7:0]        rssi_level,
  // Receive buffer
  output logic      [7:0]        rxb_data,
  output logic                   rxb_wr,
  // Modem configuration and status
  output logic      [4:0]        correlation_threshold,
  output logic                   tx_active,
  output logic                   rx_in_frame
);

  typedef struct packed {
    logic [15:0]       delimiter_pattern;
    logic [3:0]        pre_len;
    logic              auto_check_enable;
    logic [4:0]        correlation_threshold;
    logic [15:0]       rdata;
    lrw_tx_st_t        tx_st;
    logic [3:0]        tx_cnt;
    logic              tx_hi;
    logic [7:0]        tx_byte;
    logic [6:0]        tx_rem;
    logic [3:0]        tx_sym;
    logic              tx_vld;
    logic              txb_pop;
    logic              tx_underflow;
    lrw_rx_st_t        rx_st;
    logic [15:0]       rx_win;
    logic [3:0]        rx_lo;
    logic              rx_hi;
    logic [6:0]        rx_rem;
    logic [3:0]        rx_symcnt;
    logic [9:0]        corr_sum;
    logic [7:0]        rssi_avg;
    logic [7:0]        rxb_data;
    logic              rxb_wr;
    logic              crc_ok_last;
    logic              tx_act;
    logic              rx_open;
  } lrw_state_t;

  lrw_state_t  s_ff;
  lrw_state_t  nxt_s;
  logic        tx_crc_clr;
  logic        tx_crc_en;
  logic [15:0] tx_crc_q;
  logic        rx_crc_clr;
  logic        rx_crc_en;
  logic [7:0]  rx_crc_d;
  logic [15:0] rx_crc_q;

  lrw_crc16 u_tx_crc (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .crc_clr  (tx_crc_clr),
    .crc_en   (tx_crc_en),
    .crc_data (nxt_s.tx_byte),
    .crc_q    (tx_crc_q)
  );

  lrw_crc16 u_rx_crc (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .crc_clr  (rx_crc_clr),
    .crc_en   (rx_crc_en),
    .crc_data (rx_crc_d),
    .crc_q    (rx_crc_q)
  );

  always_comb
  begin
    logic              adv;
    logic [7:0]        b;
    logic [15:0]       win;
    logic signed [8:0] diff;
    logic              ok;
    adv        = ~s_ff.tx_vld | tx_sym_ready;
    b          = 8'h00;
    win        = {rx_sym, s_ff.rx_win[15:4]};
    diff       = $signed({1'b0, rssi_level}) - $signed({1'b0, s_ff.rssi_avg});
    ok         = 1'b0;
    nxt_s      = s_ff;
    tx_crc_clr = 1'b0;
    tx_crc_en  = 1'b0;
    rx_crc_clr = 1'b0;
    rx_crc_en  = 1'b0;
    rx_crc_d   = 8'h00;

    // Register port
    nxt_s.rdata   = 16'h0000;
    nxt_s.txb_pop = 1'b0;
    nxt_s.rxb_wr  = 1'b0;
    if (reg_wr)
    begin
      unique case (reg_addr)
        ADDR_PATTERN: nxt_s.delimiter_pattern = reg_wdata;
        ADDR_CTRL_A:
        begin
          nxt_s.pre_len           = reg_wdata[CTRLA_PRE_LSB +: CTRLA_PRE_W];
          nxt_s.auto_check_enable = reg_wdata[CTRLA_AUTO];
        end
        ADDR_CTRL_B:  nxt_s.correlation_threshold = reg_wdata[CTRLB_THR_LSB +: CTRLB_THR_W];
        ADDR_COMMAND:
        begin
          if (reg_wdata[CMD_UFL_CLEAR])
            nxt_s.tx_underflow = 1'b0;
        end
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_PATTERN: nxt_s.rdata = s_ff.delimiter_pattern;
        ADDR_CTRL_A:  nxt_s.rdata = 16'({s_ff.auto_check_enable, s_ff.pre_len});
        ADDR_CTRL_B:  nxt_s.rdata = 16'(s_ff.correlation_threshold);
        ADDR_STATUS:
        begin
          nxt_s.rdata[ST_UNDERFLOW] = s_ff.tx_underflow;
          nxt_s.rdata[ST_TX_ACTIVE] = (s_ff.tx_st != TX_IDLE);
          nxt_s.rdata[ST_CRC_OK]    = s_ff.crc_ok_last;
          nxt_s.rdata[ST_RX_FRAME]  = (s_ff.rx_st != RX_HUNT);
        end
        default: nxt_s.rdata = 16'h0000;
      endcase
    end

    // Transmit sequencer
    if (adv)
      nxt_s.tx_vld = 1'b0;
    unique case (s_ff.tx_st)
      TX_IDLE:
      begin
        if (reg_wr && (reg_addr == ADDR_COMMAND) && reg_wdata[CMD_TX_START])
        begin
          nxt_s.tx_st  = TX_PRE;
          nxt_s.tx_cnt = 4'h0;
          nxt_s.tx_hi  = 1'b0;
          tx_crc_clr   = 1'b1;
        end
      end
      TX_PRE:
      begin
        if (adv)
        begin
          if (s_ff.tx_cnt < s_ff.pre_len)
          begin
            nxt_s.tx_sym = SYM_ZERO;
            nxt_s.tx_vld = 1'b1;
            nxt_s.tx_cnt = s_ff.tx_cnt + 4'h1;
          end
          else
          begin
            nxt_s.tx_st  = TX_DELIM;
            nxt_s.tx_cnt = 4'h0;
          end
        end
      end
      TX_DELIM:
      begin
        if (adv)
        begin
          b            = {4'h0, s_ff.delimiter_pattern[4*s_ff.tx_cnt[1:0] +: 4]};
          nxt_s.tx_sym = (b[3:0] == SYM_IGNORE) ? SYM_ZERO : b[3:0];
          nxt_s.tx_vld = 1'b1;
          nxt_s.tx_cnt = s_ff.tx_cnt + 4'h1;
          if (s_ff.tx_cnt[1:0] == DELIM_LAST)
            nxt_s.tx_st = TX_LEN;
        end
      end
      TX_LEN, TX_BODY, TX_FCS:
      begin
        if (adv && !s_ff.tx_hi)
        begin
          if ((s_ff.tx_st != TX_FCS) && !txb_avail)
          begin
            nxt_s.tx_underflow = 1'b1;
            nxt_s.tx_st        = TX_IDLE;
          end
          else
          begin
            if (s_ff.tx_st == TX_FCS)
              b = (s_ff.tx_rem == FCS_BYTES) ? tx_crc_q[7:0] : tx_crc_q[15:8];
            else
              b = txb_data;
            if (s_ff.tx_st == TX_LEN)
              nxt_s.tx_rem = b[6:0];
            else
              nxt_s.tx_rem = s_ff.tx_rem - 7'h01;
            nxt_s.txb_pop = (s_ff.tx_st != TX_FCS);
            tx_crc_en     = (s_ff.tx_st == TX_BODY);
            nxt_s.tx_byte = b;
            nxt_s.tx_sym  = b[3:0];
            nxt_s.tx_vld  = 1'b1;
            nxt_s.tx_hi   = 1'b1;
          end
        end
        else if (adv)
        begin
          nxt_s.tx_sym = s_ff.tx_byte[7:4];
          nxt_s.tx_vld = 1'b1;
          nxt_s.tx_hi  = 1'b0;
          if (s_ff.tx_rem == 7'h00)
            nxt_s.tx_st = TX_IDLE;
          else if (s_ff.auto_check_enable && (s_ff.tx_rem <= FCS_BYTES))
            nxt_s.tx_st = TX_FCS;
          else
            nxt_s.tx_st = TX_BODY;
        end
      end
    endcase

    // Receive framer
    if (rx_sym_valid)
    begin
      nxt_s.rx_win = win;
      unique case (s_ff.rx_st)
        RX_HUNT:
        begin
          if (lrw_delim_match(win, s_ff.delimiter_pattern))
          begin
            nxt_s.rx_st     = RX_LEN;
            nxt_s.rx_hi     = 1'b0;
            nxt_s.rx_symcnt = 4'h0;
            nxt_s.corr_sum  = 10'h000;
            nxt_s.rssi_avg  = rssi_level;
            rx_crc_clr      = 1'b1;
          end
        end
        RX_LEN, RX_BODY:
        begin
          if (s_ff.rx_symcnt < CORR_SYMS)
          begin
            nxt_s.corr_sum  = s_ff.corr_sum + 10'(rx_corr);
            nxt_s.rx_symcnt = s_ff.rx_symcnt + 4'h1;
          end
          if (!s_ff.rx_hi)
          begin
            nxt_s.rx_lo = rx_sym;
            nxt_s.rx_hi = 1'b1;
          end
          else
          begin
            b              = {rx_sym, s_ff.rx_lo};
            nxt_s.rx_hi    = 1'b0;
            nxt_s.rssi_avg = s_ff.rssi_avg + 8'(diff >>> RSSI_SHIFT);
            nxt_s.rxb_wr   = 1'b1;
            nxt_s.rxb_data = b;
            if (s_ff.rx_st == RX_LEN)
            begin
              nxt_s.rx_rem = b[6:0];
              nxt_s.rx_st  = (b[6:0] == 7'h00) ? RX_HUNT : RX_BODY;
            end
            else
            begin
              rx_crc_en    = 1'b1;
              rx_crc_d     = b;
              ok           = (lrw_crc_byte(rx_crc_q, b) == CRC_INIT);
              nxt_s.rx_rem = s_ff.rx_rem - 7'h01;
              if (s_ff.auto_check_enable && (s_ff.rx_rem <= FCS_BYTES))
              begin
                if (s_ff.rx_rem == FCS_BYTES)
                  nxt_s.rxb_data = s_ff.rssi_avg;
                else
                  nxt_s.rxb_data = {ok, s_ff.corr_sum[CORR_SHIFT +: 7]};
              end
              if (s_ff.rx_rem == 7'h01)
              begin
                nxt_s.rx_st       = RX_HUNT;
                nxt_s.crc_ok_last = ok;
              end
            end
          end
        end
      endcase
    end

    // Status levels registered so the pins come straight from flops
    nxt_s.tx_act  = (nxt_s.tx_st != TX_IDLE);
    nxt_s.rx_open = (nxt_s.rx_st != RX_HUNT);
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s_ff                   <= '0;
      s_ff.delimiter_pattern <= PATTERN_RST;
      s_ff.pre_len           <= PRE_RST;
      s_ff.auto_check_enable <= AUTO_RST;
      s_ff.correlation_threshold <= THR_RST;
      s_ff.tx_st             <= TX_IDLE;
      s_ff.rx_st             <= RX_HUNT;
    end
    else
      s_ff <= nxt_s;
  end

  assign reg_rdata             = s_ff.rdata;
  assign txb_pop               = s_ff.txb_pop;
  assign tx_sym                = s_ff.tx_sym;
  assign tx_sym_valid          = s_ff.tx_vld;
  assign rxb_data              = s_ff.rxb_data;
  assign rxb_wr                = s_ff.rxb_wr;
  assign correlation_threshold = s_ff.correlation_threshold;
  assign tx_active             = s_ff.tx_act;
  assign rx_in_frame           = s_ff.rx_open;

  a_pattern_reset: assert property (@(posedge clk_sys) disable iff (srst)
    $fell(srst) |-> (s_ff.delimiter_pattern == PATTERN_RST) && (s_ff.pre_len == PRE_RST))
    else $error("pattern or preamble length not at default after reset");

  a_header_first: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(s_ff.tx_st == TX_LEN) |-> $past(s_ff.tx_st) == TX_DELIM)
    else $error("length byte started without delimiter");

  a_preamble_count: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(s_ff.tx_st == TX_DELIM) |-> $past(s_ff.tx_cnt) == $past(s_ff.pre_len))
    else $error("preamble symbol count differs from setting");

  a_delim_four: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(s_ff.tx_st == TX_LEN) |-> s_ff.tx_cnt == 4'h4)
    else $error("delimiter not four symbols");

  a_sync_match: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(s_ff.rx_st == RX_LEN) |-> lrw_delim_match(s_ff.rx_win, s_ff.delimiter_pattern))
    else $error("sync declared without pattern match");

  a_extra_zero: assert property (@(posedge clk_sys) disable iff (srst)
    ($rose(s_ff.rx_st == RX_LEN) && (s_ff.delimiter_pattern == PATTERN_RST)) |->
      (s_ff.rx_win[15:4] == 12'ha70))
    else $error("default sync without extra zero symbol");

  a_no_delim_store: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(s_ff.rx_st == RX_LEN) |-> !s_ff.rxb_wr ##1 !s_ff.rxb_wr)
    else $error("delimiter written to receive buffer");

  a_underflow_stop: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(s_ff.tx_underflow) |-> (s_ff.tx_st == TX_IDLE) && !s_ff.txb_pop)
    else $error("transmit continued after underflow");

  a_crc_flag: assert property (@(posedge clk_sys) disable iff (srst)
    ($fell(s_ff.rx_st == RX_BODY) && s_ff.auto_check_enable && s_ff.rxb_wr && $past(s_ff.rx_rem) == 7'h01) |->
      s_ff.rxb_data[7] == s_ff.crc_ok_last)
    else $error("final byte flag differs from check result");

endmodule // lrw_frame_formatter

/* File: lrw_modem_model.sv */
`timescale 1ns/1ps
module lrw_modem_model
(
  // Clock
  input  wire logic       clk_sys,
  // Transmit buffer
  input  wire logic       txb_pop,
  output logic            txb_avail,
  output logic [7:0]      txb_data,
  // Modem transmit side
  input  wire logic [3:0] tx_sym,
  input  wire logic       tx_sym_valid,
  output logic            tx_sym_ready,
  // Modem receive side
  output logic [3:0]      rx_sym,
  output logic            rx_sym_valid,
  output logic [6:0]      rx_corr,
  // Receive buffer
  input  wire logic [7:0] rxb_data,
  input  wire logic       rxb_wr
);
  logic [7:0] txq[$];
  logic [7:0] seen[$];
  logic       slow = 1'b0;
  logic [7:0] tick = 8'h00;

  initial
  begin
    txb_avail    = 1'b0;
    txb_data     = 8'h00;
    tx_sym_ready = 1'b1;
    rx_sym       = 4'h0;
    rx_sym_valid = 1'b0;
    rx_corr      = 7'h00;
  end

  // Head byte only while held; otherwise a moving pattern so stale data never matches
  always @(posedge clk_sys)
  begin
    tick <= tick + 8'h01;
    if (txb_pop && txq.size() != 0)
      void'(txq.pop_front());
    txb_avail <= (txq.size() != 0);
    txb_data  <= (txq.size() != 0) ? txq[0] : ~tick;
    if (tx_sym_valid && tx_sym_ready)
      seen.push_back({4'h0, tx_sym});
    if (rxb_wr)
      seen.push_back(rxb_data);
    tx_sym_ready <= slow ? ($urandom % 3 != 0) : 1'b1;
  end

  // One symbol pulse, then the lines change so no stale value lingers
  task automatic send_sym(input logic [3:0] s, input logic [6:0] c);
    @(posedge clk_sys);
    rx_sym       <= s;
    rx_corr      <= c;
    rx_sym_valid <= 1'b1;
    @(posedge clk_sys);
    rx_sym       <= ~s;
    rx_corr      <= ~c;
    rx_sym_valid <= 1'b0;
  endtask
endmodule // lrw_modem_model

/* File: lrw_frame_formatter_bench.sv */
`timescale 1ns/1ps
module lrw_frame_formatter_bench
  import lrw_pkg::*;
();
  logic              clk_sys = 1'b0;
  logic              srst = 1'b1;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [REG_DW-1:0] reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [REG_DW-1:0] reg_rdata;
  logic              txb_avail, txb_pop, tx_sym_valid, tx_sym_ready, rx_sym_valid, rxb_wr;
  logic              tx_active, rx_in_frame;
  logic [7:0]        txb_data, rxb_data;
  logic [7:0]        rssi_level = 8'h00;
  logic [3:0]        tx_sym, rx_sym;
  logic [6:0]        rx_corr;
  logic [4:0]        correlation_threshold;
  int                n_mismatch = 0;
  int                tests_run = 0;
  int                pat = 32'h0000a70f;
  int                exq[$];

  lrw_frame_formatter DUT (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txb_avail(txb_avail), .txb_data(txb_data),
    .txb_pop(txb_pop), .tx_sym(tx_sym), .tx_sym_valid(tx_sym_valid), .tx_sym_ready(tx_sym_ready),
    .rx_sym(rx_sym), .rx_sym_valid(rx_sym_valid), .rx_corr(rx_corr), .rssi_level(rssi_level),
    .rxb_data(rxb_data), .rxb_wr(rxb_wr), .correlation_threshold(correlation_threshold),
    .tx_active(tx_active), .rx_in_frame(rx_in_frame));

  lrw_modem_model MDL (.clk_sys(clk_sys), .txb_pop(txb_pop), .txb_avail(txb_avail), .txb_data(txb_data),
    .tx_sym(tx_sym), .tx_sym_valid(tx_sym_valid), .tx_sym_ready(tx_sym_ready), .rx_sym(rx_sym),
    .rx_sym_valid(rx_sym_valid), .rx_corr(rx_corr), .rxb_data(rxb_data), .rxb_wr(rxb_wr));

  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    chk("reg_rdata", e, reg_rdata);
  endtask

  // Reflected CRC-16, zero start, bits taken least significant first
  function automatic int crc_upd(input int c, input int d);
    for (int i = 0; i < 8; i++)
      c = (((c ^ (d >> i)) & 1) != 0) ? ((c >> 1) ^ 32'h00008408) : (c >> 1);
    return c;
  endfunction

  task automatic push_byte(input int b);
    exq.push_back(b % 16);
    exq.push_back(b / 16);
  endtask

  task automatic cmp_q(input string nm);
    chk("count", 16'(exq.size()), 16'(MDL.seen.size()));
    for (int i = 0; i < exq.size() && i < MDL.seen.size(); i++)
      chk(nm, 16'(exq[i]), {8'h00, MDL.seen[i]});
  endtask

  task automatic tx_frame(input int pre, input int au, input int len, input int give);
    int b, crc, nd;
    exq.delete();
    MDL.seen.delete();
    MDL.slow = ($urandom % 2) != 0;
    wr(ADDR_CTRL_A, 16'(au * 16 + pre));
    nd = (au != 0) ? len - 2 : len;
    crc = 0;
    MDL.txq.push_back(8'(len));
    for (int i = 0; i < pre; i++)
      exq.push_back(0);
    for (int i = 0; i < 4; i++)
      exq.push_back(((pat >> (4 * i)) % 16 == 15) ? 0 : (pat >> (4 * i)) % 16);
    push_byte(len);
    for (int i = 0; i < nd && i < give; i++)
    begin
      b = $urandom % 256;
      MDL.txq.push_back(8'(b));
      push_byte(b);
      crc = crc_upd(crc, b);
    end
    if (au != 0 && give >= nd)
      for (int i = 0; i < 4; i++)
        exq.push_back((crc >> (4 * i)) % 16);
    wr(ADDR_COMMAND, 16'h0001);
    repeat (2) @(posedge clk_sys);
    for (int k = 0; k < 4000 && (tx_active === 1'b1 || tx_sym_valid === 1'b1); k++)
      @(negedge clk_sys);
    chk("tx_active", 16'h0000, {15'h0000, tx_active});
  endtask

  task automatic rx_frame(input int au, input int len, input int bad);
    int by[$];
    int crc, cs, c, rs, skip, lv;
    exq.delete();
    MDL.seen.delete();
    wr(ADDR_CTRL_A, 16'(au * 16 + 6 + $urandom % 10));
    rs = $urandom % 256;
    rssi_level <= 8'(rs);
    by.push_back(len);
    crc = 0;
    for (int i = 0; i < len - 2; i++)
    begin
      by.push_back($urandom % 256);
      crc = crc_upd(crc, by[i + 1]);
    end
    crc = crc ^ bad;
    by.push_back(crc % 256);
    by.push_back(crc / 256);
    MDL.send_sym(4'h5, 7'h00);
    skip = 1;
    for (int i = 0; i < 4; i++)
    begin
      if ((pat >> (4 * i)) % 16 != 15)
        skip = 0;
      if (skip == 0)
        MDL.send_sym(4'((pat >> (4 * i)) % 16), 7'h7f);
    end
    @(negedge clk_sys);
    chk("rx_in_frame", 16'h0001, {15'h0000, rx_in_frame});
    cs = 0;
    for (int i = 0; i < 2 * len + 2; i++)
    begin
      c = $urandom % 128;
      lv = $urandom % 256;
      rssi_level <= 8'(lv);
      if (i < 8)
        cs = cs + c;
      if (i % 2 == 1 && i < 2 * len - 2)
        rs = rs + ((lv - rs) >>> 3);
      MDL.send_sym(4'((by[i / 2] >> (4 * (i % 2))) % 16), 7'(c));
    end
    repeat (4) @(negedge clk_sys);
    chk("rx_in_frame", 16'h0000, {15'h0000, rx_in_frame});
    for (int i = 0; i < len + 1; i++)
      exq.push_back((au == 0 || i < len - 1) ? by[i] : (i == len - 1) ? rs : (bad == 0) * 128 + cs / 8);
  endtask

  initial
  begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    void'($urandom(72913));
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    rd(ADDR_PATTERN, 16'ha70f);
    rd(ADDR_CTRL_A, 16'h0016);
    rd(ADDR_CTRL_B, 16'h0000);
    rd(8'h14, 16'h0000);
    wr(ADDR_CTRL_B, 16'h0014);
    rd(ADDR_CTRL_B, 16'h0014);
    chk("correlation_threshold", 16'h0014, {11'h000, correlation_threshold});
    tx_frame(6, 1, 5, 127);
    cmp_q("tx_sym");
    tx_frame(6, 1, 127, 127);
    cmp_q("tx_sym");
    for (int i = 0; i < 4; i++)
    begin
      tx_frame(6 + $urandom % 10, i % 2, 3 + $urandom % 20, 127);
      cmp_q("tx_sym");
    end
    tx_frame(6, 1, 9, 3);
    cmp_q("tx_sym");
    rd(ADDR_STATUS, 16'h0001);
    wr(ADDR_STATUS, 16'hffff);
    rd(ADDR_STATUS, 16'h0001);
    wr(ADDR_COMMAND, 16'h0002);
    rd(ADDR_STATUS, 16'h0000);
    for (int p = 0; p < 2; p++)
    begin
      for (int i = 0; i < 6; i++)
      begin
        rx_frame(i % 2 == 0, (i == 4) ? 127 : 3 + $urandom % 20, (i % 3 == 2) ? 16 : 0);
        cmp_q("rxb_data");
        rd(ADDR_STATUS, (i % 3 == 2) ? 16'h0000 : 16'h0004);
      end
      pat = 32'h0000a7ff;
      wr(ADDR_PATTERN, 16'ha7ff);
      rd(ADDR_PATTERN, 16'ha7ff);
      tx_frame(8, 1, 4, 127);
      cmp_q("tx_sym");
    end
    complete_run();
  end
endmodule // lrw_frame_formatter_bench
